// File: src/ddp_data_port.v
`timescale 1ns/1ns
`include "ddp_defs.vh"

module ddp_data_port #(
   parameter DATA_W   = 16,
   parameter HIST_D   = 64,
   parameter [3:0] CHIP_REVISION = 4'h1, // arbitrary value
   parameter [3:0] DEVICE_TYPE   = 4'h2  // arbitrary value
) (
   // clock and reset pin
   input  wire              clk,
   input  wire              sys_rst,
   // register port
   input  wire [7:0]        reg_addr,
   input  wire              reg_wr,
   input  wire [7:0]        reg_wdata,
   output reg  [7:0]        reg_rdata_q,
   // serial pins read as static inputs in pin mode
   input  wire              serial_data_pin,
   input  wire              chip_select_n,
   input  wire              serial_out_pin,
   // parallel link from the data source
   input  wire              frame_clock_in,
   input  wire [DATA_W-1:0] data_in,
   output reg               source_clock_out,
   // converter word pairs
   output wire              word_valid,
   input  wire              word_ready,
   output wire [DATA_W-1:0] word_i,
   output wire [DATA_W-1:0] word_q,
   // analog controls
   output wire [9:0]        aux_current_one,
   output wire              aux_one_pos_pin,
   output wire              aux_one_neg_pin,
   output wire              aux_one_direction,
   output wire [9:0]        aux_current_two,
   output wire              aux_two_pos_pin,
   output wire              aux_two_neg_pin,
   output wire              aux_two_direction,
   output wire [9:0]        conv_two_fullscale,
   output wire [1:0]        conv_one_output_mode,
   output wire [1:0]        conv_two_output_mode,
   output wire              conv_one_rz,
   output wire              conv_two_rz,
   output wire [7:0]        power_down
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;
   localparam HALF = `DDP_T_SRC_HALF_CYC;

   // registers
   reg [7:0]  data_ctrl_q;
   reg [7:0]  pd_q;
   reg [7:0]  probe_dly_q;
   reg [4:0]  capture_delay_q;
   reg [7:0]  mode_q;
   reg [7:0]  aux1_hi_q;
   reg [7:0]  aux1_lo_q;
   reg [7:0]  fs2_hi_q;
   reg [7:0]  fs2_lo_q;
   reg [7:0]  aux2_hi_q;
   reg [7:0]  aux2_lo_q;
   reg [1:0]  test_st_q;
   reg [15:0] sig1_q;
   reg [15:0] sig2_q;
   reg [15:0] res1_q;
   reg [15:0] res2_q;
   reg        probe_flag_q;
   reg        overflow_q;

   // synchronisers and link history
   reg [2:0]            pin_s1_q;
   reg [2:0]            pin_s2_q;
   reg                  fc_s1_q;
   reg                  fc_s2_q;
   reg [DATA_W-1:0]     d_s1_q;
   reg [DATA_W-1:0]     d_s2_q;
   reg [HIST_D-1:0]     fc_hist_q;
   reg [HIST_D-1:0]     edge_hist_q;
   reg [DATA_W-1:0]     d_hist_q [0:31];
   reg [7:0]            div_q;
   reg                  src_clk_q;
   reg [DATA_W-1:0]     held_i_q;
   reg                  have_i_q;
   reg [DATA_W-1:0]     buf_i_q [0:1];
   reg [DATA_W-1:0]     buf_q_q [0:1];
   reg [1:0]            cnt_q;
   reg                  rd_ptr_q;
   reg                  wr_ptr_q;
   integer              k;

   wire        wr_ok = reg_wr && !sys_rst;
   wire        strobe;
   wire        late_strobe;
   wire        word_is_i;
   wire [7:0]  late_idx;
   wire [DATA_W-1:0] cap_word;
   wire        push;
   wire        pop;
   wire        pair_done;

   // pin synchronisers, not reset: they must follow the pins during pin mode
   always @(posedge clk) begin
      pin_s1_q <= {serial_out_pin, chip_select_n, serial_data_pin};
      pin_s2_q <= pin_s1_q;
      fc_s1_q  <= frame_clock_in;
      fc_s2_q  <= fc_s1_q;
      d_s1_q   <= data_in;
      d_s2_q   <= d_s1_q;
   end

   // pin mode and writable configuration
   always @(posedge clk) begin
      if (sys_rst) begin
         data_ctrl_q     <= `DDP_R_ZERO8;
         data_ctrl_q[`DDP_B_DATA_FORMAT] <= pin_s2_q[0];
         mode_q          <= pin_s2_q[1] ? `DDP_R_MODE_PINMIX : `DDP_R_ZERO8;
         pd_q            <= pin_s2_q[2] ? `DDP_R_PD_PINALL : `DDP_R_ZERO8;
         probe_dly_q     <= `DDP_R_ZERO8;
         capture_delay_q <= 5'h00;
         aux1_hi_q       <= `DDP_R_ZERO8;
         aux1_lo_q       <= `DDP_R_ZERO8;
         fs2_hi_q        <= `DDP_R_ZERO8;
         fs2_lo_q        <= `DDP_R_ZERO8;
         aux2_hi_q       <= `DDP_R_ZERO8;
         aux2_lo_q       <= `DDP_R_ZERO8;
      end else if (wr_ok) begin
         case (reg_addr)
            `DDP_A_DATA_CTRL:     data_ctrl_q <= reg_wdata;
            `DDP_A_POWER_DOWN:    pd_q <= reg_wdata;
            `DDP_A_PROBE_DELAY:   probe_dly_q <= reg_wdata;
            `DDP_A_CAPTURE_DELAY: capture_delay_q <= reg_wdata[4:0];
            `DDP_A_OUTPUT_MODE:   mode_q <= reg_wdata;
            `DDP_A_AUX1_HIGH:     aux1_hi_q <= reg_wdata;
            `DDP_A_AUX1_LOW:      aux1_lo_q <= reg_wdata;
            `DDP_A_CONV2_FS_HIGH: fs2_hi_q <= reg_wdata;
            `DDP_A_CONV2_FS_LOW:  fs2_lo_q <= reg_wdata;
            `DDP_A_AUX2_HIGH:     aux2_hi_q <= reg_wdata;
            `DDP_A_AUX2_LOW:      aux2_lo_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // analog control words: high register holds bits 9:2, low bits 1:0
   assign aux_current_one    = {aux1_hi_q, aux1_lo_q[1:0]};
   assign aux_one_neg_pin    = aux1_lo_q[`DDP_B_PIN_SELECT];
   assign aux_one_pos_pin    = !aux1_lo_q[`DDP_B_PIN_SELECT];
   assign aux_one_direction  = aux1_lo_q[`DDP_B_DIRECTION];
   assign conv_two_fullscale = {fs2_hi_q, fs2_lo_q[1:0]};
   assign aux_current_two    = {aux2_hi_q, aux2_lo_q[1:0]};
   assign aux_two_neg_pin    = aux2_lo_q[`DDP_B_PIN_SELECT];
   assign aux_two_pos_pin    = !aux2_lo_q[`DDP_B_PIN_SELECT];
   assign aux_two_direction  = aux2_lo_q[`DDP_B_DIRECTION];
   assign power_down         = pd_q;

   // mode fields; either code with the upper bit set means return-to-zero
   assign conv_one_output_mode = mode_q[3:2];
   assign conv_two_output_mode = mode_q[1:0];
   assign conv_one_rz          = mode_q[3];
   assign conv_two_rz          = mode_q[1];

   // source clock: divider from clk, optionally inverted
   always @(posedge clk) begin
      if (sys_rst) begin
         div_q     <= 8'h00;
         src_clk_q <= 1'b0;
      end else if (div_q == HALF[7:0] - 8'h01) begin
         div_q     <= 8'h00;
         src_clk_q <= !src_clk_q;
      end else begin
         div_q     <= div_q + 8'h01;
      end
   end

   // register keeps it glitch-free; also gated by the clock-output power-down
   always @(posedge clk) begin
      if (sys_rst)
         source_clock_out <= 1'b0;
      else
         source_clock_out <= (src_clk_q ^ data_ctrl_q[`DDP_B_INVERT_SRC]) & !pd_q[7];
   end

   // link history: each tap is one clk step; delays are fixed time per step
   always @(posedge clk) begin
      if (sys_rst) begin
         fc_hist_q   <= {HIST_D{1'b0}};
         edge_hist_q <= {HIST_D{1'b0}};
      end else begin
         fc_hist_q   <= {fc_hist_q[HIST_D-2:0], fc_s2_q};
         edge_hist_q <= {edge_hist_q[HIST_D-2:0], fc_s2_q ^ fc_hist_q[0]};
      end
   end

   // data history, no reset needed: only read under a strobe
   always @(posedge clk) begin
      d_hist_q[0] <= d_s2_q;
      for (k = 1; k < 32; k = k + 1)
         d_hist_q[k] <= d_hist_q[k-1];
   end

   // capture strobe fires on both frame clock edges, delayed by capture delay
   assign strobe      = edge_hist_q[capture_delay_q];
   assign word_is_i   = fc_hist_q[capture_delay_q];
   assign cap_word    = d_hist_q[capture_delay_q];
   assign late_idx    = {3'b000, capture_delay_q} + {4'h0, probe_dly_q[3:0]};
   assign late_strobe = edge_hist_q[late_idx[5:0]];

   // probe: the early delay reaches further back into the frame clock, so
   // it samples an earlier point, while the late delay moves the strobe later
   always @(posedge clk) begin
      if (sys_rst)
         probe_flag_q <= 1'b0;
      else if (late_strobe && fc_hist_q[late_idx[5:0]])
         probe_flag_q <= fc_hist_q[late_idx[5:0] + {2'b00, probe_dly_q[7:4]}];
   end

   // demultiplex: an I word waits for its Q partner
   always @(posedge clk) begin
      if (sys_rst) begin
         have_i_q <= 1'b0;
         held_i_q <= {DATA_W{1'b0}};
      end else if (strobe && !pd_q[6]) begin
         if (word_is_i) begin
            have_i_q <= 1'b1;
            held_i_q <= cap_word;
         end else begin
            have_i_q <= 1'b0;
         end
      end
   end

   assign pair_done = strobe && !pd_q[6] && !word_is_i && have_i_q;

   // two-entry buffer toward the converters; the source cannot be stalled,
   // so a pair arriving while both entries are full is dropped and flagged
   assign push       = pair_done && (cnt_q != 2'd2);
   assign pop        = word_valid && word_ready;
   assign word_valid = (cnt_q != 2'd0);
   assign word_i     = buf_i_q[rd_ptr_q];
   assign word_q     = buf_q_q[rd_ptr_q];

   always @(posedge clk) begin
      if (sys_rst) begin
         cnt_q      <= 2'd0;
         rd_ptr_q   <= 1'b0;
         wr_ptr_q   <= 1'b0;
         overflow_q <= 1'b0;
         buf_i_q[0] <= {DATA_W{1'b0}};
         buf_i_q[1] <= {DATA_W{1'b0}};
         buf_q_q[0] <= {DATA_W{1'b0}};
         buf_q_q[1] <= {DATA_W{1'b0}};
      end else begin
         if (push) begin
            // twos complement input gets its sign bit flipped to offset form
            buf_i_q[wr_ptr_q] <= held_i_q ^ {!data_ctrl_q[`DDP_B_DATA_FORMAT],
                                             {(DATA_W-1){1'b0}}};
            buf_q_q[wr_ptr_q] <= cap_word ^ {!data_ctrl_q[`DDP_B_DATA_FORMAT],
                                             {(DATA_W-1){1'b0}}};
            wr_ptr_q <= !wr_ptr_q;
         end
         if (pop)
            rd_ptr_q <= !rd_ptr_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
         // set wins over clear by a write of one to the overflow bit of the status register
         if (pair_done && cnt_q == 2'd2)
            overflow_q <= 1'b1;
         else if (wr_ok && reg_addr == `DDP_A_PROBE_STATUS && reg_wdata[`DDP_B_OVERFLOW])
            overflow_q <= 1'b0;
      end
   end

   // self-test: crc-style signatures over I and Q pairs while running
   wire go_wr  = wr_ok && reg_addr == `DDP_A_TEST_CTRL;
   wire clr_wr = go_wr && reg_wdata[`DDP_B_TEST_CLEAR];
   wire rd_wr  = go_wr && reg_wdata[`DDP_B_TEST_READOUT];

   function [15:0] ddp_sig_step;
      input [15:0] sig;
      input [DATA_W-1:0] word;
      reg   [15:0] s;
      integer      b;
      begin
         s = sig;
         for (b = DATA_W - 1; b >= 0; b = b - 1)
            s = {s[14:0], 1'b0} ^ ((s[15] ^ word[b]) ? `DDP_R_SIG_POLY : 16'h0000);
         ddp_sig_step = s;
      end
   endfunction

   always @(posedge clk) begin
      if (sys_rst || clr_wr) begin
         test_st_q <= ST_IDLE;
         sig1_q    <= `DDP_R_SIG_SEED;
         sig2_q    <= `DDP_R_SIG_SEED;
         res1_q    <= 16'h0000;
         res2_q    <= 16'h0000;
      end else begin
         case (test_st_q)
            ST_IDLE: begin
               if (go_wr && reg_wdata[`DDP_B_TEST_GO]) begin
                  test_st_q <= ST_RUN;
                  sig1_q    <= `DDP_R_SIG_SEED;
                  sig2_q    <= `DDP_R_SIG_SEED;
               end
            end
            ST_RUN: begin
               if (go_wr && !reg_wdata[`DDP_B_TEST_GO])
                  test_st_q <= ST_IDLE;
               if (push) begin
                  sig1_q <= ddp_sig_step(sig1_q, held_i_q);
                  sig2_q <= ddp_sig_step(sig2_q, cap_word);
               end
            end
            default: test_st_q <= ST_IDLE;
         endcase
         if (rd_wr) begin
            res1_q <= sig1_q;
            res2_q <= sig2_q;
         end
      end
   end

   // register read, one cycle after the address; readout and clear read 0
   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_q <= `DDP_R_ZERO8;
      end else begin
         case (reg_addr)
            `DDP_A_DATA_CTRL:     reg_rdata_q <= data_ctrl_q;
            `DDP_A_POWER_DOWN:    reg_rdata_q <= pd_q;
            `DDP_A_PROBE_DELAY:   reg_rdata_q <= probe_dly_q;
            `DDP_A_CAPTURE_DELAY: reg_rdata_q <= {3'b000, capture_delay_q};
            `DDP_A_PROBE_STATUS:  reg_rdata_q <= {4'h0, overflow_q, 2'b00, probe_flag_q};
            `DDP_A_OUTPUT_MODE:   reg_rdata_q <= mode_q;
            `DDP_A_AUX1_HIGH:     reg_rdata_q <= aux1_hi_q;
            `DDP_A_AUX1_LOW:      reg_rdata_q <= aux1_lo_q;
            `DDP_A_CONV2_FS_HIGH: reg_rdata_q <= fs2_hi_q;
            `DDP_A_CONV2_FS_LOW:  reg_rdata_q <= fs2_lo_q;
            `DDP_A_AUX2_HIGH:     reg_rdata_q <= aux2_hi_q;
            `DDP_A_AUX2_LOW:      reg_rdata_q <= aux2_lo_q;
            `DDP_A_TEST_CTRL:     reg_rdata_q <= {test_st_q == ST_RUN, 7'h00};
            `DDP_A_SIG1_A:        reg_rdata_q <= res1_q[15:8];
            `DDP_A_SIG1_B:        reg_rdata_q <= res1_q[7:0];
            `DDP_A_SIG2_A:        reg_rdata_q <= res2_q[15:8];
            `DDP_A_SIG2_B:        reg_rdata_q <= res2_q[7:0];
            `DDP_A_CHIP_ID:       reg_rdata_q <= {CHIP_REVISION, DEVICE_TYPE};
            default:              reg_rdata_q <= `DDP_R_ZERO8;
         endcase
      end
   end

endmodule // ddp_data_port

// File: src/ddp_defs.vh
`ifndef DDP_DEFS_VH
`define DDP_DEFS_VH

// register offsets
`define DDP_A_DATA_CTRL     8'h02
`define DDP_A_POWER_DOWN    8'h03
`define DDP_A_PROBE_DELAY   8'h04
`define DDP_A_CAPTURE_DELAY 8'h05
`define DDP_A_PROBE_STATUS  8'h06
`define DDP_A_OUTPUT_MODE   8'h0A
`define DDP_A_AUX1_HIGH     8'h0D
`define DDP_A_AUX1_LOW      8'h0E
`define DDP_A_CONV2_FS_HIGH 8'h0F
`define DDP_A_CONV2_FS_LOW  8'h10
`define DDP_A_AUX2_HIGH     8'h11
`define DDP_A_AUX2_LOW      8'h12
`define DDP_A_TEST_CTRL     8'h1A
`define DDP_A_SIG1_A        8'h1B
`define DDP_A_SIG1_B        8'h1C
`define DDP_A_SIG2_A        8'h1D
`define DDP_A_SIG2_B        8'h1E
`define DDP_A_CHIP_ID       8'h1F

// field positions
`define DDP_B_DATA_FORMAT   7
`define DDP_B_INVERT_SRC    4
`define DDP_B_PIN_SELECT    7
`define DDP_B_DIRECTION     6
`define DDP_B_TEST_GO       7
`define DDP_B_TEST_READOUT  6
`define DDP_B_TEST_CLEAR    5
`define DDP_B_PROBE_FLAG    0
`define DDP_B_OVERFLOW      3

// reset and pin-mode values, and the signature polynomial
`define DDP_R_ZERO8         8'h00
`define DDP_R_ZERO10        10'h000
`define DDP_R_MODE_PINMIX   8'h05
`define DDP_R_PD_PINALL     8'hFF
`define DDP_R_SIG_SEED      16'hFFFF
`define DDP_R_SIG_POLY      16'h1021

// timing: source clock period in ns and system clock period in ns
`define DDP_T_SRC_CLK_NS    125
`define DDP_T_CLK_NS        8
`define DDP_T_SRC_HALF_CYC  ((`DDP_T_SRC_CLK_NS / `DDP_T_CLK_NS) / 2)

`endif

// File: verif/ddp_data_port_monitor.sv
`timescale 1ns/1ns
module ddp_data_port_monitor #(
   parameter       DATA_W        = 16,
   parameter [3:0] CHIP_REVISION = 4'h1,
   parameter [3:0] DEVICE_TYPE   = 4'h2
) (
   // clock, reset and pins
   input wire              clk,
   input wire              sys_rst,
   input wire              chip_select_n,
   input wire              serial_out_pin,
   // register port
   input wire [7:0]        reg_addr,
   input wire              reg_wr,
   input wire [7:0]        reg_wdata,
   input wire [7:0]        reg_rdata_q,
   // link and word side
   input wire              source_clock_out,
   input wire              word_valid,
   input wire              word_ready,
   input wire [DATA_W-1:0] word_i,
   input wire [DATA_W-1:0] word_q,
   // analog controls
   input wire [9:0]        aux_current_one,
   input wire              aux_one_pos_pin,
   input wire              aux_one_neg_pin,
   input wire              aux_one_direction,
   input wire              aux_two_neg_pin,
   input wire              aux_two_direction,
   input wire [9:0]        aux_current_two,
   input wire [9:0]        conv_two_fullscale,
   input wire [1:0]        conv_one_output_mode,
   input wire [1:0]        conv_two_output_mode,
   input wire [7:0]        power_down
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_aux_one_word:
      assert property (reg_wr && reg_addr == 8'h0D |=> aux_current_one[9:2] == $past(reg_wdata))
         else $error("aux one word not loaded");
   a_aux_one_ctrl:
      assert property (reg_wr && reg_addr == 8'h0E |=> aux_one_neg_pin == $past(reg_wdata[7])
         && aux_one_pos_pin != aux_one_neg_pin && aux_one_direction == $past(reg_wdata[6])
         && aux_current_one[1:0] == $past(reg_wdata[1:0])) else $error("aux one control");
   a_fullscale_word:
      assert property (reg_wr && reg_addr == 8'h0F |=> conv_two_fullscale[9:2] == $past(reg_wdata))
         else $error("full-scale word not loaded");
   a_aux_two_ctrl:
      assert property (reg_wr && reg_addr == 8'h12 |=> aux_two_neg_pin == $past(reg_wdata[7])
         && aux_two_direction == $past(reg_wdata[6])
         && aux_current_two[1:0] == $past(reg_wdata[1:0])) else $error("aux two control");
   // pin mode lives inside reset, so these two ignore the reset
   a_pin_power_down:
      assert property (disable iff (1'b0)
         (sys_rst && serial_out_pin)[*4] |-> power_down == 8'hFF) else $error("pin power-down");
   a_pin_mix_mode:
      assert property (disable iff (1'b0) (sys_rst && chip_select_n)[*4] |->
         conv_one_output_mode == 2'b01 && conv_two_output_mode == 2'b01) else $error("pin mix");
   a_id_read:
      assert property (reg_addr == 8'h1F |=> reg_rdata_q == {CHIP_REVISION, DEVICE_TYPE})
         else $error("id register read wrong");
   a_word_hold:
      assert property (word_valid && !word_ready |=>
         word_valid && $stable(word_i) && $stable(word_q)) else $error("stalled pair changed");
   // gated source clock may jump once on release, so only judge a settled gate;
   // the divider turns the clock every seven cycles
   a_src_clk_half:
      assert property ((!power_down[7])[*8] ##0 !$stable(source_clock_out) |=>
         $stable(source_clock_out)[*6]) else $error("source clock half period");
   a_test_clear:
      assert property (reg_wr && reg_addr == 8'h1A && reg_wdata[5] ##2 (reg_addr == 8'h1B)[*2]
         |-> reg_rdata_q == 8'h00) else $error("self-test result not cleared");

   c_pair_taken: cover property (word_valid && word_ready);
   c_pin_mode: cover property (disable iff (1'b0) sys_rst && serial_out_pin);
   c_test_start: cover property (reg_wr && reg_addr == 8'h1A && reg_wdata[7]);
endmodule // ddp_data_port_monitor

bind ddp_data_port ddp_data_port_monitor #(.DATA_W(DATA_W), .CHIP_REVISION(CHIP_REVISION),
   .DEVICE_TYPE(DEVICE_TYPE)) u_mon (.clk, .sys_rst, .chip_select_n, .serial_out_pin,
   .reg_addr, .reg_wr, .reg_wdata, .reg_rdata_q, .source_clock_out, .word_valid,
   .word_ready, .word_i, .word_q, .aux_current_one, .aux_one_pos_pin, .aux_one_neg_pin,
   .aux_one_direction, .aux_two_neg_pin,
   .aux_two_direction, .aux_current_two, .conv_two_fullscale, .conv_one_output_mode,
   .conv_two_output_mode, .power_down);

// File: verif/ddp_source_model.sv
`timescale 1ns/1ns
module ddp_source_model #(
   parameter DATA_W = 16
) (
   // control from the bench
   input  wire              run,
   input  wire [DATA_W-1:0] start_word,
   // link into the device
   output reg               frame_clock_in,
   output reg  [DATA_W-1:0] data_in
);
   localparam [DATA_W-1:0] ONE = 1;
   localparam [DATA_W-1:0] TWO = 2;
   reg [DATA_W-1:0] next_q;

   // own 125 ns frame, unrelated in phase to the device clock
   initial begin
      frame_clock_in = 1'b0;
      data_in = {DATA_W{1'b0}};
      next_q = {DATA_W{1'b0}};
      #3;
      forever begin
         if (run) begin
            frame_clock_in = 1'b1;
            data_in = next_q;
            #62;
            frame_clock_in = 1'b0;
            data_in = next_q + ONE;
            next_q = next_q + TWO;
            #63;
         end else begin
            next_q = start_word;
            data_in = ~data_in; // idle lines never hold a stale word
            #8;
         end
      end
   end
endmodule // ddp_source_model

// File: verif/dual_dac_data_port_and_control_test.sv
`timescale 1ns/1ns
module dual_dac_data_port_and_control_test;
   reg         clk, sys_rst, reg_wr, serial_data_pin, chip_select_n, serial_out_pin;
   reg         word_ready, run, fmt, crc_on;
   reg  [7:0]  reg_addr, reg_wdata, r;
   reg  [7:0]  v [0:5];
   reg  [15:0] start_word, wi, wq, s1, s2;
   reg  [31:0] seed, r32, r_rand;
   integer     fail_count, tests_run, cycles, pairs, k, p, rdy_mode;
   wire [7:0]  reg_rdata_q, power_down;
   wire [15:0] word_i, word_q, data_in;
   wire [9:0]  aux_current_one, aux_current_two, conv_two_fullscale;
   wire [1:0]  conv_one_output_mode, conv_two_output_mode;
   wire        source_clock_out, word_valid, frame_clock_in, conv_one_rz, conv_two_rz;
   wire        aux_one_pos_pin, aux_one_neg_pin, aux_one_direction;
   wire        aux_two_pos_pin, aux_two_neg_pin, aux_two_direction;

   ddp_data_port #(.CHIP_REVISION(4'h3), .DEVICE_TYPE(4'h6)) DUT (.clk, .sys_rst,
      .reg_addr, .reg_wr, .reg_wdata, .reg_rdata_q, .serial_data_pin, .chip_select_n,
      .serial_out_pin, .frame_clock_in, .data_in, .source_clock_out, .word_valid,
      .word_ready, .word_i, .word_q, .aux_current_one, .aux_one_pos_pin, .aux_one_neg_pin,
      .aux_one_direction, .aux_current_two, .aux_two_pos_pin, .aux_two_neg_pin,
      .aux_two_direction, .conv_two_fullscale, .conv_one_output_mode,
      .conv_two_output_mode, .conv_one_rz, .conv_two_rz, .power_down);
   ddp_source_model u_src (.run, .start_word, .frame_clock_in, .data_in);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task check(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task conclude;
      begin
         $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   // write strobe drops for a cycle so back-to-back calls never collide
   task wr(input [7:0] a, input [7:0] d);
      begin
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         @(posedge clk);
         #1 reg_wr = 1'b0;
         @(posedge clk);
         #1;
      end
   endtask

   task rd(input [7:0] a, output [7:0] d);
      begin
         reg_addr = a;
         repeat (2) @(posedge clk);
         #1 d = reg_rdata_q;
      end
   endtask

   task do_reset;
      begin
         sys_rst = 1'b1;
         repeat (5) @(posedge clk);
         #1 sys_rst = 1'b0;
      end
   endtask

   function [7:0] msk(input [7:0] a);
      msk = (a == 8'h0E || a == 8'h12) ? 8'hC3 : (a == 8'h10) ? 8'h03 : 8'hFF;
   endfunction

   function [15:0] crc(input [15:0] c, input [15:0] d);
      integer b;
      begin
         crc = c;
         for (b = 15; b >= 0; b = b - 1)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[b]) ? 16'h1021 : 16'h0000);
      end
   endfunction

   // stream with random stalls, then a long stall to overflow the buffer
   task stream;
      begin
         r32 = $random(seed);
         start_word = {r32[15], 7'h00, r32[7:1], 1'b0};
         wr(8'h05, {3'h0, r32[20:16]});
         run = 1'b1;
         rdy_mode = 2;
         repeat (500) @(posedge clk);
         // no early delay: the probe sees the frame clock just after it rose
         #1 wr(8'h04, 8'h00);
         repeat (40) @(posedge clk);
         #1 rd(8'h06, r);
         check(r[0], 1'b1);
         // three early steps back from a rising edge land in the low phase
         wr(8'h04, 8'h35);
         repeat (40) @(posedge clk);
         #1 rd(8'h06, r);
         check(r[0], 1'b0);
         rdy_mode = 0;
         repeat (300) @(posedge clk);
         // the last frame ends late and its pair trails by the capture delay
         #1 run = 1'b0;
         repeat (80) @(posedge clk);
         #1 rd(8'h06, r);
         check(r[3], 1'b1);
         wr(8'h06, 8'h08);
         rd(8'h06, r);
         check(r[3], 1'b0);
         rdy_mode = 1;
         repeat (20) @(posedge clk);
         #1 check(word_valid, 1'b0);
         check(pairs > 0, 1'b1);
         $display("test stream fmt=%0d done", fmt);
      end
   endtask

   always @(posedge clk) begin
      #1;
      r_rand = $random(seed);
      word_ready = (rdy_mode == 2) ? r_rand[0] : rdy_mode[0];
   end

   // every pair taken is I then Q of one frame, in the selected format;
   // signatures run over the words as the source sent them
   always @(posedge clk) begin
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
         wi = word_i ^ (fmt ? 16'h0000 : 16'h8000);
         wq = word_q ^ (fmt ? 16'h0000 : 16'h8000);
         check(wq, wi + 16'h0001);
         check({wi[15], wi[0]}, {start_word[15], 1'b0});
         pairs = pairs + 1;
         if (crc_on) begin
            s1 = crc(s1, wi);
            s2 = crc(s2, wq);
         end
      end
   end

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         conclude;
      end
   end

   initial begin
      seed = 32'hbf47;
      {fail_count, tests_run, cycles, pairs} = 0;
      {sys_rst, reg_wr, run, crc_on, word_ready} = 5'h00;
      {serial_data_pin, chip_select_n, serial_out_pin, fmt} = 4'hF;
      {reg_addr, reg_wdata, start_word} = 32'h00000000;
      rdy_mode = 1;
      #1 do_reset;
      check(power_down, 8'hFF);
      check({conv_one_output_mode, conv_two_output_mode}, 4'h5);
      rd(8'h02, r);
      check(r[7], 1'b1);
      wr(8'h03, 8'h00);
      stream;
      {serial_data_pin, chip_select_n, serial_out_pin, fmt} = 4'h0;
      do_reset;
      check(power_down, 8'h00);
      check({conv_one_output_mode, conv_two_output_mode}, 4'h0);
      rd(8'h02, r);
      check(r[7], 1'b0);
      $display("test pin mode done");
      for (p = 0; p < 4; p = p + 1) begin
         for (k = 0; k < 6; k = k + 1) begin
            r32 = $random(seed);
            v[k] = (p == 0) ? 8'hFF : (p == 1) ? 8'h00 : r32[7:0];
            wr(8'h0D + k, v[k]);
            rd(8'h0D + k, r);
            check(r & msk(8'h0D + k), v[k] & msk(8'h0D + k));
         end
         check(aux_current_one, {v[0], v[1][1:0]});
         check({aux_one_neg_pin, aux_one_pos_pin, aux_one_direction},
            {v[1][7], ~v[1][7], v[1][6]});
         check(conv_two_fullscale, {v[2], v[3][1:0]});
         check(aux_current_two, {v[4], v[5][1:0]});
         check({aux_two_neg_pin, aux_two_pos_pin, aux_two_direction},
            {v[5][7], ~v[5][7], v[5][6]});
         wr(8'h0A, {4'h0, p[1:0], p[1:0]});
         check({conv_one_output_mode, conv_one_rz, conv_two_rz},
            {p[1:0], p[1], p[1]});
      end
      wr(8'h1F, 8'h00);
      rd(8'h1F, r);
      check(r, 8'h36);
      wr(8'h30, 8'h5A);
      rd(8'h30, r);
      check(r, 8'h00);
      $display("test registers done");
      stream;
      rdy_mode = 0;
      wr(8'h1A, 8'h20);
      wr(8'h1A, 8'h80);
      rd(8'h1A, r);
      check(r[7], 1'b1);
      {s1, s2} = 32'hFFFFFFFF;
      crc_on = 1'b1;
      run = 1'b1;
      rdy_mode = 2;
      repeat (400) @(posedge clk);
      // drain every pair the signatures took before the test is stopped
      #1 rdy_mode = 1;
      run = 1'b0;
      repeat (80) @(posedge clk);
      #1 crc_on = 1'b0;
      wr(8'h1A, 8'h00);
      wr(8'h1A, 8'h40);
      for (k = 0; k < 4; k = k + 1) begin
         rd(8'h1B + k, r);
         check(r, k[1] ? (k[0] ? s2[7:0] : s2[15:8]) : (k[0] ? s1[7:0] : s1[15:8]));
      end
      wr(8'h1A, 8'h20);
      rd(8'h1B, r);
      check(r, 8'h00);
      $display("test self-test done");
      conclude;
   end
endmodule // dual_dac_data_port_and_control_test
